// File: src/sdc_spi_slave.sv
// Overview of operation
// [R1] Control bit 6 set requests a read
// [R2] Broadcast flag ignored on reads
// [R3] Unimplemented read address returns zero
// [R4] Serial output driven only in read data byte
// [R5] Broadcast write updates every chained device
// [R6] Unmapped write address changes nothing
// [R7] Serial output released for whole write
// [R8] Pass-through copies input except position ID
// [R9] Low five bits pick chain position
// [R10] Position ID decremented while passing through
// [R11] Master sends position ID bit reversed
// [R12] Received ID zero selects this device
// [R13] Non-broadcast write only at ID zero
// [R14] Unchained master always sends ID zero
// [R15] Input to pass-through path is combinational
// [R16] Shared wire: master releases during read data
// [R17] Unchained multi-device: one select per device
// [R18] Eight rising edges, select release advances byte
// [R19] Clock edge while deselected restarts packet
// [R20] Abandoned write leaves register unchanged
// [R21] Bytes shift most significant bit first
`include "sdc_regs.svh"

module sdc_spi_slave (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic spi_clk,
    input wire logic device_select_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    output logic chain_pass_output
);
    sdc_pkg::sdc_state_t st_reg;
    sdc_pkg::sdc_state_t st_next;

    logic sclk_s;
    logic csn_s;
    logic mosi_s;
    logic sclk_rise;
    logic csn_rise;
    logic id_window;
    logic spi_commit;
    logic apb_setup;
    logic apb_wr;
    logic reg_hit;
    logic map_hit;
    logic [2:0] reg_idx;
    logic [2:0] addr_idx;
    logic spi_addr_ok;
    logic shift_addr_ok;
    logic sel_s;

    sdc_sync2 u_sync_sclk (
        .pclk(pclk),
        .presetn(presetn),
        .din(spi_clk),
        .dout(sclk_s)
    );

    // Synchronised as active high so reset reads as deselected, like the idle pin: no false select edge
    sdc_sync2 u_sync_csn (
        .pclk(pclk),
        .presetn(presetn),
        .din(~device_select_n),
        .dout(sel_s)
    );

    sdc_sync2 u_sync_mosi (
        .pclk(pclk),
        .presetn(presetn),
        .din(serial_in),
        .dout(mosi_s)
    );

    assign csn_s = ~sel_s;
    assign sclk_rise = sclk_s & ~st_reg.sclk_d;
    assign csn_rise = csn_s & ~st_reg.csn_d;
    assign addr_idx = st_reg.addr[2:0];
    assign spi_addr_ok = st_reg.addr < `SDC_SPI_REG_COUNT;
    assign shift_addr_ok = st_reg.shift < `SDC_SPI_REG_COUNT;

    // Position ID bits are the last five bits of the control byte
    assign id_window = (st_reg.phase == sdc_pkg::PH_CTRL) && (st_reg.bit_cnt >= `SDC_ID_FIRST_BIT) &&
                       (st_reg.bit_cnt <= `SDC_ID_LAST_BIT);

    // Raw pin straight to the pass-through pin: no clocked stage, so chain length limits the SPI rate
    assign chain_pass_output = serial_in ^ (id_window & st_reg.borrow); // [R15] [R8] [R10]

    // Bus answers in the access cycle; read data was captured in setup
    assign apb_setup = psel & ~penable;
    assign apb_wr = psel & penable & pwrite;
    assign reg_hit = (paddr >= `SDC_APB_REG_BASE) && (paddr < `SDC_APB_REG_END);
    assign reg_idx = paddr[4:2];
    assign map_hit = reg_hit || (paddr == `SDC_APB_CTRL) || (paddr == `SDC_APB_STATUS) ||
                     (paddr == `SDC_APB_WCOUNT);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~map_hit;
    assign prdata = st_reg.prdata;

    // Only a selected read drives, and only in its data byte
    assign serial_out_oe = (st_reg.phase == sdc_pkg::PH_DATA) && st_reg.read_not_write_flag &&
                           st_reg.selected && !csn_s; // [R4] [R7] [R12] [R2]
    assign serial_out = st_reg.tx[7]; // [R21]

    always_comb begin
        st_next = st_reg;
        spi_commit = 1'b0;
        st_next.sclk_d = sclk_s;
        st_next.csn_d = csn_s;

        if (apb_setup) begin
            st_next.prdata = 32'h0;
            if (paddr == `SDC_APB_CTRL) begin
                st_next.prdata[`SDC_CTRL_WEN_BIT] = st_reg.spi_write_en;
            end else if (paddr == `SDC_APB_STATUS) begin
                st_next.prdata[4:0] = {st_reg.broadcast_write_flag, st_reg.read_not_write_flag,
                                       st_reg.selected, st_reg.phase};
            end else if (paddr == `SDC_APB_WCOUNT) begin
                st_next.prdata[7:0] = st_reg.wcount;
            end else if (reg_hit) begin
                st_next.prdata[7:0] = st_reg.regs[reg_idx];
            end
        end

        if (apb_wr) begin
            if (paddr == `SDC_APB_CTRL) begin
                st_next.spi_write_en = pwdata[`SDC_CTRL_WEN_BIT];
            end else if (paddr == `SDC_APB_WCOUNT) begin
                st_next.wcount = 8'h00;
            end else if (reg_hit) begin
                st_next.regs[reg_idx] = pwdata[7:0];
            end
        end

        if (sclk_rise && csn_s) begin
            // Deselected clock edge: next byte is a control byte
            st_next.phase = sdc_pkg::PH_CTRL; // [R19]
            st_next.bit_cnt = 4'h0;
            st_next.borrow = 1'b1;
            st_next.id_zero = 1'b1;
        end else if (sclk_rise) begin
            st_next.shift = {st_reg.shift[6:0], mosi_s}; // [R21] [R18]
            if (st_reg.bit_cnt != `SDC_BIT_OVER) begin
                st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
            end
            if (id_window) begin
                // ID arrives LSB first, so the borrow ripples serially
                st_next.borrow = st_reg.borrow & ~mosi_s; // [R10] [R11]
                st_next.id_zero = st_reg.id_zero & ~mosi_s; // [R9] [R12]
            end
            if (st_reg.phase == sdc_pkg::PH_DATA) begin
                st_next.tx = {st_reg.tx[6:0], 1'b0};
            end
        end else if (csn_rise) begin
            st_next.bit_cnt = 4'h0;
            if (st_reg.bit_cnt == `SDC_BYTE_BITS) begin
                unique case (st_reg.phase)
                    sdc_pkg::PH_CTRL: begin
                        st_next.phase = sdc_pkg::PH_ADDR; // [R18]
                        st_next.broadcast_write_flag = st_reg.shift[`SDC_BCAST_BIT];
                        st_next.read_not_write_flag = st_reg.shift[`SDC_READ_BIT]; // [R1]
                        st_next.selected = st_reg.id_zero; // [R12]
                    end
                    sdc_pkg::PH_ADDR: begin
                        st_next.phase = sdc_pkg::PH_DATA;
                        st_next.addr = st_reg.shift;
                        st_next.tx = shift_addr_ok ? st_reg.regs[st_reg.shift[2:0]] : 8'h00; // [R3]
                    end
                    sdc_pkg::PH_DATA: begin
                        // Commit only on a complete data byte; broadcast has no say on reads
                        if (!st_reg.read_not_write_flag && spi_addr_ok && st_reg.spi_write_en &&
                            (st_reg.broadcast_write_flag || st_reg.selected)) begin // [R2] [R5] [R6] [R13]
                            spi_commit = 1'b1;
                        end
                        st_next.phase = sdc_pkg::PH_CTRL;
                        st_next.borrow = 1'b1;
                        st_next.id_zero = 1'b1;
                    end
                    sdc_pkg::PH_LOST: begin
                        st_next.phase = sdc_pkg::PH_LOST;
                    end
                endcase
            end else if (st_reg.bit_cnt != 4'h0) begin
                // Short or long byte: packet dropped until resynchronised
                st_next.phase = sdc_pkg::PH_LOST; // [R20]
            end
        end

        if (spi_commit) begin
            st_next.regs[addr_idx] = st_reg.shift; // [R5]
            st_next.wcount = (apb_wr && paddr == `SDC_APB_WCOUNT) ? 8'h01 : st_reg.wcount + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.sclk_d <= 1'b0;
            st_reg.csn_d <= 1'b1;
            st_reg.phase <= sdc_pkg::PH_CTRL;
            st_reg.borrow <= 1'b1;
            st_reg.id_zero <= 1'b1;
            st_reg.regs <= {8{`SDC_SPI_REG_RESET}};
            st_reg.spi_write_en <= `SDC_CTRL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_byte_done;
        csn_rise && !sclk_rise && (st_reg.bit_cnt == `SDC_BYTE_BITS);
    endsequence

    sequence s_data_done;
        s_byte_done ##0 (st_reg.phase == sdc_pkg::PH_DATA);
    endsequence

    property p_oe_read_data;
        serial_out_oe |-> (st_reg.phase == sdc_pkg::PH_DATA) && st_reg.read_not_write_flag;
    endproperty
    a_oe_read_data: assert property (p_oe_read_data) else $error("Serial output driven outside read data"); // [R4]

    property p_oe_write_off;
        !st_reg.read_not_write_flag |-> !serial_out_oe;
    endproperty
    a_oe_write_off: assert property (p_oe_write_off) else $error("Serial output driven during write"); // [R7]

    property p_oe_selected;
        !st_reg.selected |-> !serial_out_oe;
    endproperty
    a_oe_selected: assert property (p_oe_selected) else $error("Unselected device drives output"); // [R12]

    property p_pass_copy;
        !id_window |-> (chain_pass_output == serial_in);
    endproperty
    a_pass_copy: assert property (p_pass_copy) else $error("Pass-through altered outside ID"); // [R8]

    property p_id_zero_selects;
        s_byte_done ##0 (st_reg.phase == sdc_pkg::PH_CTRL) ##0 st_reg.id_zero |=> st_reg.selected;
    endproperty
    a_id_zero_selects: assert property (p_id_zero_selects) else $error("ID zero did not select"); // [R12]

    property p_byte_advance;
        s_byte_done ##0 (st_reg.phase == sdc_pkg::PH_CTRL) |=>
            (st_reg.phase == sdc_pkg::PH_ADDR) && (st_reg.bit_cnt == 4'h0);
    endproperty
    a_byte_advance: assert property (p_byte_advance) else $error("Byte counter did not advance"); // [R18]

    property p_reinit;
        sclk_rise && csn_s |=> (st_reg.phase == sdc_pkg::PH_CTRL) && (st_reg.bit_cnt == 4'h0) && st_reg.borrow;
    endproperty
    a_reinit: assert property (p_reinit) else $error("Deselected clock did not restart packet"); // [R19]

    property p_unmapped_read;
        s_byte_done ##0 (st_reg.phase == sdc_pkg::PH_ADDR) ##0 !shift_addr_ok |=> (st_reg.tx == 8'h00);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero"); // [R3]

    property p_broadcast_write;
        s_data_done ##0 (st_reg.broadcast_write_flag && !st_reg.read_not_write_flag && spi_addr_ok &&
                         st_reg.spi_write_en) |=> (st_reg.regs[$past(addr_idx)] == $past(st_reg.shift));
    endproperty
    a_broadcast_write: assert property (p_broadcast_write) else $error("Broadcast write not stored"); // [R5]

    property p_commit_gate;
        spi_commit |-> !st_reg.read_not_write_flag && (st_reg.broadcast_write_flag || st_reg.selected);
    endproperty
    a_commit_gate: assert property (p_commit_gate) else $error("Write by unselected device or read"); // [R13]

    property p_unmapped_write;
        s_data_done ##0 !spi_addr_ok ##0 !apb_wr |=> $stable(st_reg.regs);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("Unmapped write changed a register"); // [R6]

    property p_abandon;
        (st_reg.phase == sdc_pkg::PH_DATA) && csn_rise && !sclk_rise && (st_reg.bit_cnt != `SDC_BYTE_BITS) &&
            !apb_wr |=> $stable(st_reg.regs) && (st_reg.phase != sdc_pkg::PH_DATA);
    endproperty
    a_abandon: assert property (p_abandon) else $error("Abandoned write changed a register"); // [R20]

    property p_oe_deselected;
        csn_s |-> !serial_out_oe;
    endproperty
    a_oe_deselected: assert property (p_oe_deselected) else $error("Output driven while deselected"); // [R4]

    property p_bit_sample;
        sclk_rise && !csn_s |=> (st_reg.shift[0] == $past(mosi_s));
    endproperty
    a_bit_sample: assert property (p_bit_sample) else $error("Sampled bit lost"); // [R18]

    property p_tx_shift;
        (st_reg.phase == sdc_pkg::PH_DATA) && sclk_rise && !csn_s |=> (st_reg.tx[7] == $past(st_reg.tx[6]));
    endproperty
    a_tx_shift: assert property (p_tx_shift) else $error("Read data not shifted out in order"); // [R21]

    property p_borrow_stop;
        id_window && sclk_rise && !csn_s && mosi_s |=> !st_reg.borrow;
    endproperty
    a_borrow_stop: assert property (p_borrow_stop) else $error("Borrow kept past a one bit"); // [R10]

    property p_addr_advance;
        s_byte_done ##0 (st_reg.phase == sdc_pkg::PH_ADDR) |=> (st_reg.phase == sdc_pkg::PH_DATA);
    endproperty
    a_addr_advance: assert property (p_addr_advance) else $error("Address byte did not advance"); // [R18]

    property p_packet_end;
        s_data_done |=> (st_reg.phase == sdc_pkg::PH_CTRL) && st_reg.borrow && st_reg.id_zero;
    endproperty
    a_packet_end: assert property (p_packet_end) else $error("Packet did not restart"); // [R18]

    property p_short_byte;
        csn_rise && !sclk_rise && (st_reg.bit_cnt != `SDC_BYTE_BITS) && (st_reg.bit_cnt != 4'h0) |=>
            (st_reg.phase == sdc_pkg::PH_LOST);
    endproperty
    a_short_byte: assert property (p_short_byte) else $error("Short byte did not drop packet"); // [R20]

    property p_lost_hold;
        (st_reg.phase == sdc_pkg::PH_LOST) && !(sclk_rise && csn_s) |=> (st_reg.phase == sdc_pkg::PH_LOST);
    endproperty
    a_lost_hold: assert property (p_lost_hold) else $error("Lost packet resumed without resync"); // [R19]

    property p_read_no_commit;
        st_reg.read_not_write_flag |-> !spi_commit;
    endproperty
    a_read_no_commit: assert property (p_read_no_commit) else $error("Read committed a write"); // [R2]

    property p_wen_gate;
        !st_reg.spi_write_en |-> !spi_commit;
    endproperty
    a_wen_gate: assert property (p_wen_gate) else $error("Write committed while disabled");

    property p_select_write;
        s_data_done ##0 (!st_reg.broadcast_write_flag && st_reg.selected && !st_reg.read_not_write_flag &&
                         spi_addr_ok && st_reg.spi_write_en) |=>
            (st_reg.regs[$past(addr_idx)] == $past(st_reg.shift));
    endproperty
    a_select_write: assert property (p_select_write) else $error("Addressed write not stored"); // [R13]

    property p_wcount_step;
        spi_commit && !(apb_wr && (paddr == `SDC_APB_WCOUNT)) |=> (st_reg.wcount == $past(st_reg.wcount) + 8'h01);
    endproperty
    a_wcount_step: assert property (p_wcount_step) else $error("Write count did not step");
endmodule

// File: src/sdc_regs.svh
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

// SPI packet layout
`define SDC_BYTE_BITS 4'h8
`define SDC_BIT_OVER 4'h9
`define SDC_ID_FIRST_BIT 4'h3
`define SDC_ID_LAST_BIT 4'h7
`define SDC_BCAST_BIT 7
`define SDC_READ_BIT 6
`define SDC_SPI_REG_COUNT 8'h08
`define SDC_SPI_REG_RESET 8'h00

// APB register map
`define SDC_APB_CTRL 12'h000
`define SDC_APB_STATUS 12'h004
`define SDC_APB_WCOUNT 12'h008
`define SDC_APB_REG_BASE 12'h040
`define SDC_APB_REG_END 12'h060
`define SDC_CTRL_WEN_BIT 0
`define SDC_CTRL_RESET 1'h1

`endif

// File: src/sdc_pkg.sv
package sdc_pkg;

    typedef enum logic [1:0] {
        PH_CTRL,
        PH_ADDR,
        PH_DATA,
        PH_LOST
    } sdc_phase_t;

    typedef struct packed {
        logic sclk_d;
        logic csn_d;
        sdc_phase_t phase;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic borrow;
        logic id_zero;
        logic selected;
        logic read_not_write_flag;
        logic broadcast_write_flag;
        logic [7:0] addr;
        logic [7:0] tx;
        logic [7:0][7:0] regs;
        logic spi_write_en;
        logic [7:0] wcount;
        logic [31:0] prdata;
    } sdc_state_t;

endpackage

// File: src/sdc_sync2.sv
module sdc_sync2 (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic din,
    output logic dout
);
    logic meta_reg;

    // The first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule

// File: verif/sdc_spi_master.sv
module sdc_spi_master (
    input wire logic pclk,
    output logic spi_clk,
    output logic device_select_n, // One dedicated select for the one device
    output logic serial_in, // Separate return wire, so no release in read data is needed
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic chain_pass_output
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        spi_clk = 1'b0;
        device_select_n = 1'b1;
        serial_in = 1'b0;
    end
    // Half of the 400 ns link period
    task automatic half();
        repeat (4) @(posedge pclk);
    endtask
    // Short frames abandon the packet; clock stays low between frames
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx, output logic [7:0] pass,
                        output logic oe);
        rx = 8'h00;
        pass = 8'h00;
        oe = 1'b0;
        @(posedge pclk);
        device_select_n <= 1'b0;
        for (int i = 7; i > 7 - nb; i--) begin
            serial_in <= tx[i];
            half();
            // A released return line reads inverted so a late enable cannot pass for data
            rx[i] = serial_out_oe ? serial_out : ~serial_out;
            pass[i] = chain_pass_output;
            oe |= serial_out_oe;
            spi_clk <= 1'b1;
            half();
            spi_clk <= 1'b0;
        end
        half();
        device_select_n <= 1'b1;
        // Released line flips so a stale bit cannot pass for data
        serial_in <= ~serial_in;
        half();
        half();
    endtask
    // Clock edge with select high restarts the packet
    task automatic resync();
        @(posedge pclk);
        spi_clk <= 1'b1;
        half();
        spi_clk <= 1'b0;
        half();
    endtask
endmodule

// File: verif/spi_slave_daisy_chain_test.sv
module spi_slave_daisy_chain_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, wr_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic spi_clk, device_select_n, serial_in, serial_out, serial_out_oe, chain_pass_output;
    logic [7:0] model_regs[8];
    logic [4:0] ids[5] = '{5'd1, 5'd12, 5'd31, 5'd3, 5'd0};
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;
    int wr_cnt = 0;
    sdc_spi_slave i_sdc_spi_slave (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .spi_clk(spi_clk), .device_select_n(device_select_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe), .chain_pass_output(chain_pass_output));
    sdc_spi_master i_sdc_spi_master (.pclk(pclk), .spi_clk(spi_clk), .device_select_n(device_select_n),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .chain_pass_output(chain_pass_output));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic final_report();
        $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check_regs();
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 12'h040 + 12'(4 * i), 32'h0);
            check(rd, {24'h0, model_regs[i]});
        end
    endtask
    // Expected pass-through and register effects follow the serial decrement model
    task automatic packet(input logic [7:0] ctrl, input logic [7:0] addr, input logic [7:0] data, input int nb);
        logic [7:0] rx, pass;
        logic oe, sel;
        logic [4:0] id, nid;
        id = {<<{ctrl[4:0]}};
        nid = id - 5'd1;
        sel = (id == 5'd0);
        i_sdc_spi_master.xfer(ctrl, 8, rx, pass, oe);
        check(pass, {ctrl[7:5], {<<{nid}}});
        check(oe, 1'b0);
        i_sdc_spi_master.xfer(addr, 8, rx, pass, oe);
        check(pass, addr);
        check(oe, 1'b0);
        i_sdc_spi_master.xfer(data, nb, rx, pass, oe);
        check(oe, ctrl[6] & sel);
        if (ctrl[6] && sel) begin
            check(rx, addr < 8 ? model_regs[addr[2:0]] : 8'h00);
        end
        if (nb == 8) begin
            check(pass, data);
        end
        if (!ctrl[6] && nb == 8 && wr_en && addr < 8 && (ctrl[7] || sel)) begin
            model_regs[addr[2:0]] = data;
            wr_cnt++;
        end
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        wr_en = 1'b1;
        foreach (model_regs[i]) model_regs[i] = 8'h00;
        void'($urandom(32'h636b));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h1);
        apb(1'b0, 12'h0f0, 32'h0);
        check({rd[30:0], err}, 32'h1);
        check_regs();
        $display("test reset done");
        for (int a = 0; a < 8; a++) packet(8'h00, 8'(a), 8'($urandom), 8);
        check_regs();
        for (int a = 0; a < 9; a++) packet(a == 8 ? 8'hc0 : 8'h40, a == 8 ? 8'h20 : 8'(a), 8'($urandom), 8);
        $display("test read write done");
        // Position ID is placed bit reversed by the master
        foreach (ids[i]) packet({3'b000, {<<{ids[i]}}}, 8'($urandom % 8), 8'($urandom), 8);
        packet({3'b100, {<<{ids[2]}}}, 8'h05, 8'($urandom), 8);
        packet(8'h00, 8'h10, 8'($urandom), 8);
        packet(8'h50, 8'h01, 8'($urandom), 8);
        check_regs();
        $display("test chain done");
        packet(8'h00, 8'h03, ~model_regs[3], 4);
        i_sdc_spi_master.resync();
        packet(8'h00, 8'h03, 8'($urandom), 8);
        check_regs();
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'(wr_cnt));
        apb(1'b1, 12'h008, 32'h0);
        wr_cnt = 0;
        $display("test abandon done");
        apb(1'b1, 12'h000, 32'h0);
        wr_en = 1'b0;
        packet(8'h80, 8'h02, 8'($urandom), 8);
        apb(1'b1, 12'h000, 32'h1);
        wr_en = 1'b1;
        apb(1'b1, 12'h048, 32'h5a);
        model_regs[2] = 8'h5a;
        packet(8'h40, 8'h02, 8'($urandom), 8);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h0000000c);
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'(wr_cnt));
        check_regs();
        $display("test control done");
        final_report();
    end
endmodule
